// File: verilog/tdmhst_defs.svh
// timing counts, field positions and frame layout for the multiplexed host port
// assumes a 25 MHz core clock and a sink device that samples on rising bit clock
// What this block does
// - half-duty frame sync when mode unwanted
// - one frame sync per audio sample
// - whole frame fits in one frame period
// - fields 32 bits, MSB first, low byte void
// - command field first after frame sync
// - extended flag adds field, drops audio
// - chain select low addresses input chain
// - ids run one to thirty
// - all chained devices act on id 31 writes
// - host sends id-assign flag in mode
// - host supplies audio for enabled channels
// - sample rising edge, drive falling edge
// - audio 24 bits MSB first, zero filled
`ifndef TDMHST_DEFS_SVH
`define TDMHST_DEFS_SVH
`define TDMHST_CORE_PERIOD_NS 40
`define TDMHST_BCK_PERIOD_NS 320
`define TDMHST_BCK_HALF ((`TDMHST_BCK_PERIOD_NS) / (2 * `TDMHST_CORE_PERIOD_NS))
`define TDMHST_FIELD_BITS 32
`define TDMHST_FRAME_BITS 128
`define TDMHST_SYNC_BITS 2
`define TDMHST_SHORT_CNT (`TDMHST_SYNC_BITS * 2 * `TDMHST_BCK_HALF)
`define TDMHST_HALF_CNT ((`TDMHST_FRAME_BITS / 2) * 2 * `TDMHST_BCK_HALF)
`define TDMHST_BIT_ASSIGN 31
`define TDMHST_BIT_EXT 30
`define TDMHST_BIT_CHAIN 29
`define TDMHST_BIT_READ 23
`define TDMHST_ID_BROADCAST 5'h1f
`define TDMHST_ID_NONE 5'h00
`define TDMHST_ID_MAX 5'h1e
`endif

// File: verilog/tdmhst_pkg.sv
// types for the multiplexed command and audio host port
// assumes tdmhst_defs.svh for all numeric constants
package tdmhst_pkg;
	// one register command as the user hands it over
	typedef struct packed {
		logic       read;
		logic [4:0] dev_id;
		logic [6:0] reg_id;
		logic [7:0] data;
	} tdmhst_cmd_type;

	// mode of the frames being sent, gray along the entry path
	typedef enum logic [1:0] {
		TDMHST_OFF    = 2'b00,
		TDMHST_ENTRY1 = 2'b01,
		TDMHST_ENTRY2 = 2'b11,
		TDMHST_LIVE   = 2'b10
	} tdmhst_mode_type;
endpackage : tdmhst_pkg

// File: verilog/tdmhst_sync.sv
// two-stage synchroniser for a level coming from a pin
// assumes the input is asynchronous to clk
`timescale 1ns/100ps
module tdmhst_sync (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic din,
	output logic      dout
);
	logic meta;

	// first stage read only by the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= 1'b0;
			dout <= 1'b0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule : tdmhst_sync

// File: verilog/tdmhst_host.sv
// host end of the multiplexed command and audio port: makes bit clock and frame sync,
// shifts command, extended and audio fields out, collects read data from the return line
// assumes one sink device chain whose return line is resolved outside this block
`timescale 1ns/100ps
`include "tdmhst_defs.svh"
module tdmhst_host (
	input  wire logic                     CORE_CLK,
	input  wire logic                     RST_N,
	input  wire logic                     TDM_EN,
	input  wire logic                     CMD_VALID,
	input  wire logic                     CMD_ASSIGN,
	input  wire logic                     CMD_EXT,
	input  wire tdmhst_pkg::tdmhst_cmd_type CMD_REQ,
	input  wire tdmhst_pkg::tdmhst_cmd_type EXT_REQ,
	output logic                          CMD_READY,
	input  wire logic [23:0]              AUD_LEFT,
	input  wire logic [23:0]              AUD_RIGHT,
	output logic                          AUD_TAKEN,
	input  wire logic                     RETURN_IN,
	output logic                          BIT_CLOCK,
	output logic                          FRAME_SYNC,
	output logic                          SERIAL_OUT,
	output logic                          MODE_LIVE,
	output logic                          RD_VALID,
	output logic [7:0]                    RD_DATA,
	output logic [7:0]                    RD_EXT_DATA
);
	localparam int HALF = `TDMHST_BCK_HALF;

	logic [3:0]                  ph;
	logic [6:0]                  bitcnt;
	logic [127:0]                frame_sh;
	logic                        frame_short;
	logic                        rd_cmd;
	logic                        rd_ext;
	logic                        pend;
	logic                        pend_assign;
	logic                        pend_ext;
	tdmhst_pkg::tdmhst_cmd_type  pend_cmd;
	tdmhst_pkg::tdmhst_cmd_type  pend_xcmd;
	tdmhst_pkg::tdmhst_mode_type mode;
	tdmhst_pkg::tdmhst_mode_type next_mode;
	logic [7:0]                  rx_cmd;
	logic [7:0]                  rx_ext;
	logic                        ret_s;
	logic [9:0]                  sync_cnt;

	// return line passes two flops before it is sampled
	tdmhst_sync u_ret_sync (
		.clk   (CORE_CLK),
		.rst_n (RST_N),
		.din   (RETURN_IN),
		.dout  (ret_s)
	);

	// bit clock phase events
	wire rise_ev   = (ph == 4'(HALF - 1));
	wire fall_ev   = (ph == 4'(2 * HALF - 1));
	wire frame_end = fall_ev && (bitcnt == 7'(`TDMHST_FRAME_BITS - 1));

	// mode walk at each frame boundary; dropping the enable falls back to off at the next boundary
	always_comb begin
		unique case (mode)
			tdmhst_pkg::TDMHST_OFF:    next_mode = TDM_EN ? tdmhst_pkg::TDMHST_ENTRY1 : tdmhst_pkg::TDMHST_OFF;
			tdmhst_pkg::TDMHST_ENTRY1: next_mode = TDM_EN ? tdmhst_pkg::TDMHST_ENTRY2 : tdmhst_pkg::TDMHST_OFF;
			tdmhst_pkg::TDMHST_ENTRY2: next_mode = TDM_EN ? tdmhst_pkg::TDMHST_LIVE : tdmhst_pkg::TDMHST_OFF;
			tdmhst_pkg::TDMHST_LIVE:   next_mode = TDM_EN ? tdmhst_pkg::TDMHST_LIVE : tdmhst_pkg::TDMHST_OFF;
		endcase
	end

	// what the next frame carries
	wire next_live  = (next_mode == tdmhst_pkg::TDMHST_LIVE);
	wire next_short = (next_mode != tdmhst_pkg::TDMHST_OFF);
	wire send_cmd   = next_live && pend;
	wire send_asg   = send_cmd && pend_assign;
	wire send_ext   = send_cmd && !pend_assign && pend_ext;
	wire send_rd    = send_cmd && !pend_assign && pend_cmd.read;
	wire send_xrd   = send_ext && pend_xcmd.read;

	// command field: chain select held low for the input chain, low byte zero
	wire [31:0] cmd_word = send_asg ? {1'b1, 31'h0} :
		send_cmd ? {1'b0, send_ext, 1'b0, pend_cmd.dev_id,
		pend_cmd.read, pend_cmd.reg_id, pend_cmd.data, 8'h00} : 32'h0;
	// extended field: bit 31 reserved zero
	wire [31:0] ext_word = {1'b0, 1'b0, 1'b0, pend_xcmd.dev_id,
		pend_xcmd.read, pend_xcmd.reg_id, pend_xcmd.data, 8'h00};
	// audio fields: 24-bit sample on top, zeros below
	wire        send_aud = next_short && !send_ext && !send_asg;
	wire [31:0] left_w   = send_aud ? {AUD_LEFT, 8'h00} : 32'h0;
	wire [31:0] right_w  = send_aud ? {AUD_RIGHT, 8'h00} : 32'h0;
	wire [127:0] next_frame = send_ext ? {cmd_word, ext_word, 64'h0} :
		{cmd_word, left_w, right_w, 32'h0};

	// user handshake
	wire take_cmd   = CMD_VALID && CMD_READY;
	wire load_frame = frame_end;
	wire next_pend  = take_cmd ? 1'b1 : (load_frame && send_cmd) ? 1'b0 : pend;

	// frame sync level for the bit about to start
	wire [6:0] next_bit  = frame_end ? 7'h0 : 7'(bitcnt + 7'h1);
	wire       next_sync = (frame_end ? next_short : frame_short) ?
		(next_bit < 7'(`TDMHST_SYNC_BITS)) :
		(next_bit < 7'(`TDMHST_FRAME_BITS / 2));

	// read data sits in bits 15..8 of the field; nothing is taken from the low byte
	wire in_data = (bitcnt[4:3] == 2'b10);
	wire cap_cmd = rise_ev && rd_cmd && (bitcnt[6:5] == 2'd0) && in_data;
	wire cap_ext = rise_ev && rd_ext && (bitcnt[6:5] == 2'd1) && in_data;

	// bit clock divider, low half then high half
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ph        <= 4'h0;
			BIT_CLOCK <= 1'b0;
		end else begin
			ph        <= fall_ev ? 4'h0 : 4'(ph + 4'h1);
			BIT_CLOCK <= rise_ev ? 1'b1 : fall_ev ? 1'b0 : BIT_CLOCK;
		end
	end

	// data and sync change only on the falling edge; one frame per sample period
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			bitcnt      <= 7'h7f;
			frame_sh    <= '0;
			FRAME_SYNC  <= 1'b0;
			frame_short <= 1'b0;
		end else if (fall_ev) begin
			bitcnt      <= next_bit;
			frame_sh    <= frame_end ? next_frame : {frame_sh[126:0], 1'b0};
			FRAME_SYNC  <= next_sync;
			frame_short <= frame_end ? next_short : frame_short;
		end
	end

	// msb of the shifter is the pin
	assign SERIAL_OUT = frame_sh[127];

	// mode and pending command bookkeeping
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			mode      <= tdmhst_pkg::TDMHST_OFF;
			MODE_LIVE <= 1'b0;
			pend      <= 1'b0;
			CMD_READY <= 1'b0;
			AUD_TAKEN <= 1'b0;
			rd_cmd    <= 1'b0;
			rd_ext    <= 1'b0;
		end else begin
			mode      <= load_frame ? next_mode : mode;
			MODE_LIVE <= load_frame ? next_live : MODE_LIVE;
			pend      <= next_pend;
			CMD_READY <= !next_pend;
			AUD_TAKEN <= load_frame && send_aud;
			rd_cmd    <= load_frame ? send_rd : rd_cmd;
			rd_ext    <= load_frame ? send_xrd : rd_ext;
		end
	end

	// captured request, held until its frame is loaded
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			pend_assign <= 1'b0;
			pend_ext    <= 1'b0;
			pend_cmd    <= '0;
			pend_xcmd   <= '0;
		end else if (take_cmd) begin
			pend_assign <= CMD_ASSIGN;
			pend_ext    <= CMD_EXT;
			pend_cmd    <= CMD_REQ;
			pend_xcmd   <= EXT_REQ;
		end
	end

	// read bytes shift in msb first; result shows after the frame ends
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rx_cmd      <= 8'h00;
			rx_ext      <= 8'h00;
			RD_VALID    <= 1'b0;
			RD_DATA     <= 8'h00;
			RD_EXT_DATA <= 8'h00;
		end else begin
			rx_cmd      <= cap_cmd ? {rx_cmd[6:0], ret_s} : rx_cmd;
			rx_ext      <= cap_ext ? {rx_ext[6:0], ret_s} : rx_ext;
			RD_VALID    <= frame_end && (rd_cmd || rd_ext);
			RD_DATA     <= (frame_end && rd_cmd) ? rx_cmd : RD_DATA;
			RD_EXT_DATA <= (frame_end && rd_ext) ? rx_ext : RD_EXT_DATA;
		end
	end

	// helper: core cycles the frame sync has stayed high
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			sync_cnt <= 10'h000;
		end else begin
			sync_cnt <= FRAME_SYNC ? 10'(sync_cnt + 10'h001) : 10'h000;
		end
	end

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);

	sync_short_a : assert property ($fell(FRAME_SYNC) && frame_short |->
		$past(sync_cnt) == 10'(`TDMHST_SHORT_CNT - 1))
		else $error("short frame sync not two bit clocks");
	sync_half_a : assert property ($fell(FRAME_SYNC) && !frame_short |->
		$past(sync_cnt) == 10'(`TDMHST_HALF_CNT - 1))
		else $error("frame sync not half duty");
	entry_gate_a : assert property (load_frame && cmd_word != 32'h0 |->
		mode == tdmhst_pkg::TDMHST_ENTRY2 || mode == tdmhst_pkg::TDMHST_LIVE)
		else $error("command sent before mode entry");
	chain_low_a : assert property (load_frame |-> !next_frame[127 - (31 - `TDMHST_BIT_CHAIN)])
		else $error("chain select not low");
	assign_only_a : assert property (load_frame && next_frame[127] |->
		next_frame[126:0] == 127'h0)
		else $error("id assign frame carries other bits");
	ext_noaud_a : assert property (load_frame && next_frame[126] |-> next_frame[63:0] == 64'h0)
		else $error("audio sent with extended field");
	low_byte_a : assert property (load_frame |-> next_frame[103:96] == 8'h00 &&
		next_frame[71:64] == 8'h00)
		else $error("low byte of field not zero");
	fall_drive_a : assert property ($changed(SERIAL_OUT) || $changed(FRAME_SYNC) |->
		$fell(BIT_CLOCK))
		else $error("pin moved off falling edge");
	ready_drop_a : assert property (take_cmd |=> pend && !CMD_READY)
		else $error("second command taken while one pends");

	live_c : cover property ($rose(MODE_LIVE));
	read_c : cover property (RD_VALID && rd_ext);
	assign_c : cover property (load_frame && send_asg);
	audio_c : cover property (AUD_TAKEN && MODE_LIVE);
endmodule : tdmhst_host

// File: verification/tdmhst_dev_model.sv
// sink device model: frames in on bit clock, registers, reads answered on a shared line
// assumes a pull-up on the return line outside; top of chain when chain input is high
`timescale 1ns/100ps
module tdmhst_dev_model (
	input  wire logic         bit_clock,
	input  wire logic         frame_sync,
	input  wire logic         serial_in,
	input  wire logic         chain_input,
	output logic              return_out,
	output logic              return_oe,
	output logic [4:0]        own_id,
	output logic [31:0]       aud_l,
	output logic [31:0]       aud_r,
	output logic              chain_output
);
	logic [31:0] sh;
	logic [7:0]  regs [128];
	logic [7:0]  rd_byte;
	logic        prev_fs = 1'b0, acc = 1'b0, ext = 1'b0, rd_go = 1'b0, fok;
	int          bit_n = 0, nshort = 0, pos = 0, fld = 0;
	// no id until an assign frame arrives
	initial begin
		own_id = 5'h00;
		return_out = 1'b0;
		chain_output = 1'b0;
	end
	// frame starts where sync rises; only pulses that are low again by bit two count toward entry
	always @(posedge bit_clock) begin
		bit_n = (frame_sync && !prev_fs) ? 0 : bit_n + 1;
		prev_fs = frame_sync;
		sh = {sh[30:0], serial_in};
		pos = bit_n % 32;
		fld = bit_n / 32;
		if (bit_n == 2) begin
			acc = !frame_sync && nshort >= 2;
			nshort = frame_sync ? 0 : nshort + 1;
		end
		fok = acc && (fld == 0 || (fld == 1 && ext));
		if (pos == 0)
			rd_go = 1'b0;
		// header is whole by bit 15, so the answer fits the same field's data phase
		if (fok && pos == 14)
			rd_go = !(fld == 0 && sh[14]) && !sh[12] && sh[6] && sh[11:7] == own_id && own_id != 5'h00;
		if (fok && pos == 15)
			rd_byte = regs[sh[6:0]];
		if (fok && pos == 31 && fld == 0)
			ext = sh[30] && !sh[31];
		if (fok && pos == 31 && fld == 0 && sh[31])
			own_id = chain_input ? 5'h01 : own_id;
		else if (fok && pos == 31 && !sh[29] && !sh[23] && (sh[28:24] == 5'h1f || sh[28:24] == own_id && own_id != 5'h00))
			regs[sh[22:16]] = sh[15:8];
		if (acc && !ext && pos == 31 && fld == 1)
			aud_l = sh;
		if (acc && !ext && pos == 31 && fld == 2)
			aud_r = sh;
		// hands the next slot on while its own last channel passes
		chain_output = acc && !ext && fld == 2 && own_id != 5'h00;
	end
	// drive on the falling edge, enabled one bit early, released before the low byte
	always @(negedge bit_clock) begin
		return_oe = rd_go && pos >= 14 && pos <= 22;
		return_out = (pos >= 15 && pos <= 22) ? rd_byte[22 - pos] : !return_out;
	end
endmodule : tdmhst_dev_model

// File: verification/testbench.sv
// self-checking bench: host port driving one sink device model
// assumes the host, its package and the device model compile first
`timescale 1ns/100ps
`define TDMHST_CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
	$display("mismatch %0t got %0h exp %0h", $time, (a), (b)); end end
module testbench;
	logic                       CORE_CLK, RST_N, TDM_EN, CMD_VALID, CMD_ASSIGN, CMD_EXT, CMD_READY, AUD_TAKEN;
	logic                       RETURN_IN, BIT_CLOCK, FRAME_SYNC, SERIAL_OUT, MODE_LIVE, RD_VALID;
	logic                       ret_out, ret_oe, rd_seen, chain_out, chain_seen;
	logic [23:0]                AUD_LEFT, AUD_RIGHT;
	logic [7:0]                 RD_DATA, RD_EXT_DATA;
	logic [4:0]                 own_id;
	logic [31:0]                aud_l, aud_r;
	tdmhst_pkg::tdmhst_cmd_type CMD_REQ, EXT_REQ;
	int                         errors = 0, n_tests = 0, n_frames = 0, ready_frames = 0;
	// shared return line, pulled up while nobody drives it
	assign RETURN_IN = (ret_oe === 1'b1) ? ret_out : 1'b1;
	tdmhst_host tdmhst_host_inst (
		.CORE_CLK(CORE_CLK), .RST_N(RST_N), .TDM_EN(TDM_EN), .CMD_VALID(CMD_VALID), .CMD_ASSIGN(CMD_ASSIGN),
		.CMD_EXT(CMD_EXT), .CMD_REQ(CMD_REQ), .EXT_REQ(EXT_REQ), .CMD_READY(CMD_READY), .AUD_LEFT(AUD_LEFT),
		.AUD_RIGHT(AUD_RIGHT), .AUD_TAKEN(AUD_TAKEN), .RETURN_IN(RETURN_IN), .BIT_CLOCK(BIT_CLOCK),
		.FRAME_SYNC(FRAME_SYNC), .SERIAL_OUT(SERIAL_OUT), .MODE_LIVE(MODE_LIVE), .RD_VALID(RD_VALID),
		.RD_DATA(RD_DATA), .RD_EXT_DATA(RD_EXT_DATA)
	);
	tdmhst_dev_model tdmhst_dev_model_inst (
		.bit_clock(BIT_CLOCK), .frame_sync(FRAME_SYNC), .serial_in(SERIAL_OUT), .chain_input(1'b1),
		.return_out(ret_out), .return_oe(ret_oe), .own_id(own_id), .aud_l(aud_l), .aud_r(aud_r),
		.chain_output(chain_out)
	);
	// 25 MHz core clock
	initial begin
		CORE_CLK = 1'b0;
		forever #20 CORE_CLK = ~CORE_CLK;
	end
	// frame count, and a sticky flag since read-done lasts one cycle
	always @(posedge FRAME_SYNC) n_frames++;
	always @(posedge CORE_CLK) if (RD_VALID === 1'b1) rd_seen <= 1'b1;
	// chain output looked at on the falling bit clock, away from the model's update
	always @(negedge BIT_CLOCK) if (chain_out === 1'b1) chain_seen <= 1'b1;
	task automatic cyc(input int n);
		repeat (n) @(negedge CORE_CLK);
	endtask : cyc
	task automatic next_frames(input int m);
		int k;
		k = n_frames + m;
		for (int i = 0; i < 3000 * m && n_frames < k; i++) cyc(1);
	endtask : next_frames
	// one request; returns once the frame carrying it has ended
	task automatic send(input logic asg, input logic ext,
		input tdmhst_pkg::tdmhst_cmd_type c, input tdmhst_pkg::tdmhst_cmd_type e);
		for (int i = 0; i < 5000 && CMD_READY !== 1'b1; i++) cyc(1);
		{CMD_VALID, CMD_ASSIGN, CMD_EXT, CMD_REQ, EXT_REQ} = {1'b1, asg, ext, c, e};
		cyc(1);
		CMD_VALID = 1'b0;
		cyc(1);
		for (int i = 0; i < 5000 && CMD_READY !== 1'b1; i++) cyc(1);
		ready_frames = n_frames;
		rd_seen = 1'b0;
		next_frames(1);
		cyc(4);
	endtask : send
	task automatic cmd(input logic rd, input logic [4:0] id, input logic [6:0] r, input logic [7:0] d);
		send(1'b0, 1'b0, {rd, id, r, d}, '0);
	endtask : cmd
	task automatic t_sync(input logic en, input int hi_exp);
		int hi, per, k;
		TDM_EN = en;
		next_frames(2);
		k = n_frames;
		for (hi = 0; FRAME_SYNC === 1'b1 && hi < 2000; hi++) cyc(1);
		for (per = 0; n_frames == k && per < 2000; per++) cyc(1);
		`TDMHST_CHK(hi, hi_exp)
		`TDMHST_CHK(hi + per, 1024)
		`TDMHST_CHK(MODE_LIVE, en)
	endtask : t_sync
	task automatic t_entry;
		int k;
		k = n_frames;
		TDM_EN = 1'b1;
		send(1'b1, 1'b0, '0, '0);
		`TDMHST_CHK(ready_frames - k, 3)
		`TDMHST_CHK(own_id, 5'h01)
	endtask : t_entry
	task automatic t_regs;
		logic [4:0] ids [3];
		ids = '{5'h00, 5'h02, 5'h1e};
		cmd(1'b0, 5'h01, 7'h05, 8'ha5);
		cmd(1'b1, 5'h01, 7'h05, 8'h00);
		`TDMHST_CHK(rd_seen, 1'b1)
		`TDMHST_CHK(RD_DATA, 8'ha5)
		cmd(1'b0, 5'h1f, 7'h06, 8'h3c);
		foreach (ids[i]) cmd(1'b0, ids[i], 7'h06, 8'h77);
		cmd(1'b1, 5'h01, 7'h06, 8'h00);
		`TDMHST_CHK(RD_DATA, 8'h3c)
		cmd(1'b1, 5'h02, 7'h05, 8'h00);
		`TDMHST_CHK(RD_DATA, 8'hff)
	endtask : t_regs
	task automatic t_ext;
		send(1'b0, 1'b1, {1'b0, 5'h01, 7'h07, 8'h5a}, {1'b1, 5'h01, 7'h05, 8'h00});
		`TDMHST_CHK(RD_EXT_DATA, 8'ha5)
		cmd(1'b1, 5'h01, 7'h07, 8'h00);
		`TDMHST_CHK(RD_DATA, 8'h5a)
	endtask : t_ext
	task automatic t_audio;
		AUD_LEFT = 24'h123456;
		AUD_RIGHT = 24'hfedcba;
		for (int i = 0; i < 2000 && AUD_TAKEN !== 1'b1; i++) cyc(1);
		chain_seen = 1'b0;
		next_frames(1);
		`TDMHST_CHK(chain_seen, 1'b1)
		`TDMHST_CHK(aud_l, 32'h12345600)
		`TDMHST_CHK(aud_r, 32'hfedcba00)
	endtask : t_audio
	task automatic final_report;
		$display("comparisons %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : final_report
	// half-duty run comes first so that mode entry starts from off
	initial begin
		{RST_N, TDM_EN, CMD_VALID, CMD_ASSIGN, CMD_EXT, rd_seen, chain_seen} = 7'h00;
		{CMD_REQ, EXT_REQ, AUD_LEFT, AUD_RIGHT} = '0;
		cyc(4);
		RST_N = 1'b1;
		cyc(2);
		t_sync(1'b0, 512);
		t_entry();
		t_sync(1'b1, 16);
		t_regs();
		t_ext();
		t_audio();
		t_sync(1'b0, 512);
		final_report();
	end
	// hang guard, well past the expected run length
	initial begin
		#3000000;
		errors++;
		final_report();
	end
endmodule : testbench
